//--- design/pmc_ctrl.sv
// global power mode controller top
`timescale 1ns/1ps
module pmc_ctrl (
   input  wire logic                     clk_sys_i,
   input  wire logic                     srst_i,
   input  wire logic                     mode_req_i,
   input  wire logic [1:0]               mode_sel_i,
   input  wire logic [pmc_pkg::NSUB-1:0] act_tmpl_i,
   input  wire logic                     act_tmpl_we_i,
   input  wire logic [pmc_pkg::NSUB-1:0] alt_tmpl_i,
   input  wire logic                     alt_tmpl_we_i,
   input  wire logic [pmc_pkg::WCW-1:0]  wake_intv_i,
   input  wire logic                     wake_intv_we_i,
   input  wire logic                     wake_cnt_clr_i,
   input  wire logic                     low_speed_oscillator_tick_i,
   output logic [pmc_pkg::NSUB-1:0]      clk_en_o,
   output logic [pmc_pkg::NSUB-1:0]      bias_en_o,
   output logic [1:0]                    mode_o,
   output logic [pmc_pkg::NSUB-1:0]      act_tmpl_o,
   output logic [pmc_pkg::NSUB-1:0]      alt_tmpl_o,
   output logic                          all_clk_stop_o,
   output logic                          lsclk_sel_o,
   output logic                          wake_o
);
   typedef enum logic [1:0] {
      PMC_ST_ACTIVE,
      PMC_ST_ALT,
      PMC_ST_SLEEP,
      PMC_ST_HIB
   } pmc_state_e;

   pmc_state_e              st_r;
   pmc_state_e              st_nxt;
   pmc_state_e              req_st;
   logic [pmc_pkg::NSUB-1:0] act_r;
   logic [pmc_pkg::NSUB-1:0] act_nxt;
   logic [pmc_pkg::NSUB-1:0] alt_r;
   logic [pmc_pkg::NSUB-1:0] alt_nxt;
   logic [pmc_pkg::WCW-1:0]  intv_r;
   logic [pmc_pkg::WCW-1:0]  intv_nxt;
   logic [pmc_pkg::NSUB-1:0] en_r;
   logic [pmc_pkg::NSUB-1:0] en_nxt;
   logic                     tick_s1_r;
   logic                     tick_s2_r;
   logic                     tick_d_r;
   logic                     tick_pls;
   logic                     wake_pls;
   logic                     wake_r;

   // the oscillator tick is asynchronous: two stages before edge detect
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         tick_s1_r <= 1'b0;
         tick_s2_r <= 1'b0;
         tick_d_r  <= 1'b0;
      end else begin
         tick_s1_r <= low_speed_oscillator_tick_i;
         tick_s2_r <= tick_s1_r;
         tick_d_r  <= tick_s2_r;
      end
   end
   assign tick_pls = tick_s2_r & ~tick_d_r;

   // counter runs in every mode except hibernate
   pmc_wake_counter u_wake (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .run_i     (st_r != PMC_ST_HIB),
      .clr_i     (wake_cnt_clr_i),
      .tick_i    (tick_pls),
      .intv_i    (intv_r),
      .wake_o    (wake_pls)
   );

   // map a request select onto the state it asks for; 0 means stay active
   function automatic pmc_state_e sel_to_state(input logic [1:0] sel);
      pmc_state_e st;
      case (sel)
         2'h1:    st = PMC_ST_ALT;
         2'h2:    st = PMC_ST_SLEEP;
         2'h3:    st = PMC_ST_HIB;
         default: st = PMC_ST_ACTIVE;
      endcase
      return st;
   endfunction

   assign req_st = sel_to_state(mode_sel_i);

   // mode sequencing
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         PMC_ST_ACTIVE: begin
            if (mode_req_i) begin
               st_nxt = req_st;
            end
         end
         // from alternate active only a lower mode may be requested
         PMC_ST_ALT: begin
            if (wake_pls) begin
               st_nxt = PMC_ST_ACTIVE;
            end else if (mode_req_i &&
                         (req_st == PMC_ST_SLEEP ||
                          req_st == PMC_ST_HIB)) begin
               st_nxt = req_st;
            end
         end
         PMC_ST_SLEEP: begin
            if (wake_pls) begin
               st_nxt = PMC_ST_ACTIVE;
            end
         end
         // only srst_i leaves hibernate
         PMC_ST_HIB: st_nxt = PMC_ST_HIB;
         default:    st_nxt = PMC_ST_ACTIVE;
      endcase
   end

   // templates, wake interval and resulting enables
   always_comb begin
      act_nxt  = act_r;
      alt_nxt  = alt_r;
      intv_nxt = intv_r;
      if (act_tmpl_we_i) begin
         act_nxt = act_tmpl_i;
      end
      if (alt_tmpl_we_i) begin
         alt_nxt = alt_tmpl_i;
      end
      if (wake_intv_we_i) begin
         intv_nxt = wake_intv_i;
      end
      // any wakeup, in active mode too, re-enables the cpu in the
      // template, so a self-disable lasts only until the next wake;
      // a same-cycle write loses on the cpu bit only
      if (wake_pls) begin
         act_nxt[pmc_pkg::CPU_BIT] = 1'b1;
      end
      case (st_nxt)
         PMC_ST_ACTIVE: en_nxt = act_nxt;
         PMC_ST_ALT:    en_nxt = alt_nxt;
         PMC_ST_SLEEP:  en_nxt = pmc_pkg::SLEEP_KEEP;
         PMC_ST_HIB:    en_nxt = '0;
         default:       en_nxt = act_nxt;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         st_r   <= PMC_ST_ACTIVE;
         act_r  <= pmc_pkg::ACT_TMPL_RST;
         alt_r  <= pmc_pkg::ALT_TMPL_RST;
         intv_r <= pmc_pkg::WAKE_INTV_RST;
         en_r   <= pmc_pkg::ACT_TMPL_RST;
         wake_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         act_r  <= act_nxt;
         alt_r  <= alt_nxt;
         intv_r <= intv_nxt;
         en_r   <= en_nxt;
         wake_r <= wake_pls;
      end
   end

   // clock gate and bias follow the same enable, so neither can lag
   for (genvar g = 0; g < pmc_pkg::NSUB; g++) begin : g_sub
      assign clk_en_o[g]  = en_r[g];
      assign bias_en_o[g] = en_r[g];
   end
   assign mode_o         = st_r;
   assign act_tmpl_o     = act_r;
   assign alt_tmpl_o     = alt_r;
   assign all_clk_stop_o = (st_r == PMC_ST_HIB);
   assign lsclk_sel_o    = (st_r == PMC_ST_SLEEP);
   assign wake_o         = wake_r;
endmodule

//--- design/pmc_pkg.sv
// constants and types for the global power mode controller
// Summary of operation
// - Four global modes exist, ranked by consumption: active, alternate active, sleep, hibernate.
// - In active mode each subsystem is enabled or disabled by its own bit of the active template.
// - Template bits may change at any time in active mode and take effect at once.
// - A disabled subsystem has its digital clock gated and its analog bias enable deasserted.
// - The CPU may disable itself by its template bit and is re-enabled at the next wakeup.
// - Any wakeup returns the mode to active and enables the CPU regardless of templates, unless a mode request is taken in active mode in the same cycle.
// - Active is the mode after reset.
// - Alternate active enables a reduced set, for example CPU and flash off, peripherals on.
// - Sleep disables most resources automatically, overriding the templates.
// - Hibernate stops all clocks while retaining state and leaves only through reset.
// - In sleep the periodic wake counter wakes the device periodically, at most every 128 ms.
// - Sleep is left on a periodic wake counter event or on a system reset.
package pmc_pkg;
   localparam int NSUB       = 8;
   localparam int CPU_BIT    = 0;
   localparam int FLASH_BIT  = 1;
   localparam logic [NSUB-1:0] ACT_TMPL_RST = 8'hff;
   localparam logic [NSUB-1:0] ALT_TMPL_RST = 8'hfc;
   // subsystems that stay alive in sleep (none: only the wake counter runs)
   localparam logic [NSUB-1:0] SLEEP_KEEP   = 8'h00;
   // wake counter: low-speed tick is 1 kHz, longest interval 128 ms
   localparam int WAKE_MAX_MS   = 128;
   localparam int TICK_HZ       = 1000;
   localparam int WAKE_MAX_TICK = WAKE_MAX_MS * TICK_HZ / 1000;
   localparam int WCW           = 8;
   localparam logic [WCW-1:0] WAKE_INTV_RST = 8'h80;
   typedef enum logic [1:0] {
      PMC_REQ_ACTIVE,
      PMC_REQ_ALT,
      PMC_REQ_SLEEP,
      PMC_REQ_HIB
   } pmc_mode_e;
endpackage

//--- design/pmc_wake_counter.sv
// periodic wake counter running on synchronised low-speed ticks
`timescale 1ns/1ps
module pmc_wake_counter (
   input  wire logic                    clk_sys_i,
   input  wire logic                    srst_i,
   input  wire logic                    run_i,
   input  wire logic                    clr_i,
   input  wire logic                    tick_i,
   input  wire logic [pmc_pkg::WCW-1:0] intv_i,
   output logic                         wake_o
);
   logic [pmc_pkg::WCW-1:0] cnt_r;
   logic [pmc_pkg::WCW-1:0] cnt_nxt;
   logic                    wake_r;
   logic                    wake_nxt;
   logic [pmc_pkg::WCW-1:0] lim;

   // intervals above the maximum are clipped; zero reads as one tick
   always_comb begin
      lim = intv_i;
      if (intv_i > pmc_pkg::WCW'(pmc_pkg::WAKE_MAX_TICK)) begin
         lim = pmc_pkg::WCW'(pmc_pkg::WAKE_MAX_TICK);
      end
      if (lim == '0) begin
         lim = 8'h01;
      end
      cnt_nxt  = cnt_r;
      wake_nxt = 1'b0;
      if (clr_i || !run_i) begin
         cnt_nxt = '0;
      end else if (tick_i) begin
         if (cnt_r + 8'h01 >= lim) begin
            cnt_nxt  = '0;
            wake_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         cnt_r  <= '0;
         wake_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         wake_r <= wake_nxt;
      end
   end

   assign wake_o = wake_r;
endmodule

//--- verification/pmc_ctrl_bench.sv
// self-checking bench for the global power mode controller
`timescale 1ns/1ps
module pmc_ctrl_bench;
   logic       clk_sys_i = 1'b0, srst = 1'b1, mreq = 1'b0, act_we = 1'b0;
   logic       alt_we = 1'b0, intv_we = 1'b0, clr = 1'b1, tick = 1'b0;
   logic [1:0] msel = 2'h0;
   logic [7:0] act = 8'h00, alt = 8'h00, intv = 8'h03, en, bias, at, lt;
   logic [1:0] mode;
   logic       stop, ls, wake;
   int         num_errors = 0, n_checks = 0, wakes = 0, i;
   // rows: request select, expected mode, expected clock enables
   logic [11:0] tbl [4] = '{12'h0ff, 12'h5fc, 12'ha00, 12'hf00};
   pmc_ctrl u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst), .mode_req_i(mreq),
      .mode_sel_i(msel), .act_tmpl_i(act), .act_tmpl_we_i(act_we),
      .alt_tmpl_i(alt), .alt_tmpl_we_i(alt_we), .wake_intv_i(intv),
      .wake_intv_we_i(intv_we), .wake_cnt_clr_i(clr),
      .low_speed_oscillator_tick_i(tick), .clk_en_o(en), .bias_en_o(bias),
      .mode_o(mode), .act_tmpl_o(at), .alt_tmpl_o(lt),
      .all_clk_stop_o(stop), .lsclk_sel_o(ls), .wake_o(wake));
   always #2.5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (wake === 1'b1) wakes++;
   task cyc(input int n); repeat (n) @(posedge clk_sys_i); endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task rst; srst <= 1'b1; cyc(5); srst <= 1'b0; cyc(1); endtask
   task req(input logic [1:0] s);
      mreq <= 1'b1; msel <= s; cyc(1); mreq <= 1'b0; cyc(2);
   endtask
   task wr(input logic a, input logic [7:0] v);
      act <= v; alt <= v; act_we <= a; alt_we <= !a; cyc(1);
      act_we <= 1'b0; alt_we <= 1'b0; cyc(2);
   endtask
   // tick runs slow compared with the system clock so the sync sees it
   task ticks(input int n);
      for (i = 0; i < n && wakes == 0; i++) begin
         tick <= 1'b1; cyc(4); tick <= 1'b0; cyc(4);
      end
   endtask
   task end_sim;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      num_errors++;
      end_sim;
   end
   initial begin
      cyc(1);
      foreach (tbl[k]) begin
         rst;
         req(tbl[k][11:10]);
         chk(mode, tbl[k][9:8]);
         chk(en, tbl[k][7:0]);
         chk(bias, tbl[k][7:0]);
         chk(ls, tbl[k][9:8] == 2'h2);
         chk(stop, tbl[k][9:8] == 2'h3);
      end
      $display("table done");
      rst;
      chk(mode, 8'h00);
      chk(at, 8'hff);
      chk(lt, 8'hfc);
      chk(bias, 8'hff);
      wr(1'b1, 8'h5a);
      chk(en, 8'h5a);
      chk(bias, 8'h5a);
      chk(at, 8'h5a);
      wr(1'b1, 8'hfe);
      chk(en, 8'hfe);
      intv_we <= 1'b1; cyc(1); intv_we <= 1'b0;
      // sleep is asked only once interval and templates are set up
      req(2'h2);
      clr <= 1'b0; wakes = 0;
      ticks(8);
      cyc(4);
      clr <= 1'b1;
      chk(8'(wakes), 8'h01);
      chk(mode, 8'h00);
      chk(en, 8'hff);
      chk(at, 8'hff);
      // a wake while active must also undo a cpu self-disable
      wr(1'b1, 8'hfe);
      clr <= 1'b0; wakes = 0;
      ticks(8);
      cyc(4);
      clr <= 1'b1;
      chk(8'(wakes), 8'h01);
      chk(mode, 8'h00);
      chk(en, 8'hff);
      $display("wake done");
      wr(1'b0, 8'h3c);
      req(2'h1);
      chk(en, 8'h3c);
      chk(lt, 8'h3c);
      req(2'h0);
      req(2'h1);
      chk(mode, 8'h01);
      req(2'h3);
      clr <= 1'b0; wakes = 0;
      ticks(6);
      chk(mode, 8'h03);
      chk(8'(wakes), 8'h00);
      chk(stop, 8'h01);
      chk(en, 8'h00);
      rst;
      chk(mode, 8'h00);
      $display("alt and hibernate done");
      end_sim;
   end
endmodule

//--- verification/pmc_ctrl_monitor.sv
// port checker for the global power mode controller
`timescale 1ns/1ps
module pmc_ctrl_monitor (
   input wire logic                     clk_sys_i,
   input wire logic                     srst_i,
   input wire logic                     mode_req_i,
   input wire logic [1:0]               mode_sel_i,
   input wire logic [pmc_pkg::NSUB-1:0] clk_en_o,
   input wire logic [pmc_pkg::NSUB-1:0] bias_en_o,
   input wire logic [1:0]               mode_o,
   input wire logic [pmc_pkg::NSUB-1:0] act_tmpl_o,
   input wire logic [pmc_pkg::NSUB-1:0] alt_tmpl_o,
   input wire logic                     all_clk_stop_o,
   input wire logic                     lsclk_sel_o,
   input wire logic                     wake_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   AST_BIAS_TRACK: assert property (bias_en_o == clk_en_o)
      else $error("bias enable differs from clock enable");
   AST_SLEEP_GATE: assert property (mode_o == 2'h2 |->
      clk_en_o == 8'h00 && lsclk_sel_o) else $error("sleep not gated");
   AST_HIB_STOP: assert property (mode_o == 2'h3 |-> all_clk_stop_o)
      else $error("hibernate clocks running");
   AST_HIB_HOLD: assert property (mode_o == 2'h3 |=> mode_o == 2'h3)
      else $error("hibernate left without reset");
   AST_SLEEP_HOLD: assert property (mode_o == 2'h2 |=>
      mode_o == 2'h2 || wake_o) else $error("sleep left without wake");
   AST_REQ_TAKEN: assert property (mode_o == 2'h0 && mode_req_i &&
      mode_sel_i != 2'h0 |=> mode_o == $past(mode_sel_i) || wake_o)
      else $error("mode request not taken");
   AST_ALT_REFUSE: assert property (mode_o == 2'h1 && mode_req_i &&
      mode_sel_i < 2'h2 |=> mode_o == 2'h1 || wake_o)
      else $error("alternate mode left by request");
   AST_WAKE_CPU: assert property (wake_o |-> mode_o == 2'h0 &&
      clk_en_o[pmc_pkg::CPU_BIT]) else $error("wake without cpu");
   AST_ACT_TMPL: assert property (mode_o == 2'h0 &&
      $past(mode_o) == 2'h0 && $stable(act_tmpl_o) |->
      clk_en_o == act_tmpl_o)
      else $error("active enables differ from template");
   AST_ALT_TMPL: assert property (mode_o == 2'h1 &&
      $past(mode_o) == 2'h1 && $stable(alt_tmpl_o) |->
      clk_en_o == alt_tmpl_o)
      else $error("alternate enables differ from template");
endmodule
bind pmc_ctrl pmc_ctrl_monitor u_mon (.clk_sys_i, .srst_i, .mode_req_i,
   .mode_sel_i, .clk_en_o, .bias_en_o, .mode_o, .act_tmpl_o, .alt_tmpl_o,
   .all_clk_stop_o, .lsclk_sel_o, .wake_o);
